// >>> hsr_pkg.sv
/*
  shared constants and types for the high-speed two-wire write receiver:
  address and control byte layout, channel register widths, reset values,
  receive phases.
  assumes nothing beyond a SystemVerilog-2012 compiler.
*/
package hsr_pkg;

  // channel geometry
  localparam int NUM_CH = 4;
  localparam int DATA_W = 12;
  localparam int PD_W = 2;
  localparam int CH_W = PD_W + DATA_W;
  localparam int SEL_W = 2;

  // address byte: fixed part, pin part, direction bit
  localparam logic [4:0] ADDR_FIXED = 5'h13;
  localparam int ADDR_FIX_LSB = 3;
  localparam int ADDR_PIN_LSB = 1;
  localparam int ADDR_RW_BIT = 0;
  localparam logic ADDR_RW_WRITE = 1'h0;

  // high-speed master code: top five bits, low three are free
  localparam logic [4:0] MCODE_TOP = 5'h01;
  localparam int MCODE_LSB = 3;

  // control byte fields
  localparam int CTRL_KIND_BIT = 0;
  localparam int CTRL_SEL_LSB = 1;
  localparam int CTRL_LOAD_LSB = 4;
  localparam logic [1:0] LOAD_SEL = 2'h1;
  localparam int LOAD_ALL_BIT = 1;

  // data byte fields
  localparam int PD_HI_LSB = 6;
  localparam int LOW_NIB_LSB = 4;

  // bit counting
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // reset values
  localparam logic [CH_W-1:0] CH_RST = 14'h0000;
  localparam logic [PD_W-1:0] PD_NORMAL = 2'h0;
  localparam logic [3:0] LINE_IDLE = 4'hc;

  typedef enum logic [3:0] {
    PH_IDLE,
    PH_MCODE,
    PH_ADDR,
    PH_CTRL,
    PH_HIGH,
    PH_LOW,
    PH_PDHI,
    PH_PDLO,
    PH_IGNORE
  } hsr_phase_t;

endpackage

// >>> hsr_ifs.sv
/*
  interfaces between the receiver's own modules: the synchronised line view
  and the channel write port.
  assumes hsr_pkg is compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

// synchronised bus levels and detected line events
interface hsr_line_if;
  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic [1:0] addr;
  modport src (output scl, sda, scl_rise, scl_fall, start_det, stop_det, addr);
  modport snk (input scl, sda, scl_rise, scl_fall, start_det, stop_det, addr);
endinterface

// one write/update strobe broadcast to every channel
interface hsr_wr_if;
  logic hold_en;
  logic upd;
  logic pd_only;
  logic [hsr_pkg::SEL_W-1:0] sel;
  logic [1:0] load;
  logic [hsr_pkg::DATA_W-1:0] data;
  logic [hsr_pkg::PD_W-1:0] pd;
  modport drv (output hold_en, upd, pd_only, sel, load, data, pd);
  modport chan (input hold_en, upd, pd_only, sel, load, data, pd);
endinterface

`default_nettype wire

// >>> hsr_link_sync.sv
/*
  two-flop synchroniser for the bus pins and address pins, plus edge and
  start/stop detection on the synchronised levels.
  assumes core_clk is several times faster than the bus clock.
*/
`timescale 1ns/1ps
`default_nettype none

module hsr_link_sync
  import hsr_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic addr_pin_hi,
  input wire logic addr_pin_lo,
  hsr_line_if.src line
);

  logic [3:0] meta_q;
  logic [3:0] sync_q;
  logic scl_prev_q;
  logic sda_prev_q;

  // bus pins idle high, address pins reset low; the first stage is read only by the second
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= LINE_IDLE;
      sync_q <= LINE_IDLE;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      meta_q <= {scl_i, sda_i, addr_pin_hi, addr_pin_lo};
      sync_q <= meta_q;
      scl_prev_q <= sync_q[3];
      sda_prev_q <= sync_q[2];
    end
  end

  // events: sda moving while scl stays high marks start or stop
  assign line.scl = sync_q[3];
  assign line.sda = sync_q[2];
  assign line.addr = sync_q[1:0];
  assign line.scl_rise = sync_q[3] & ~scl_prev_q;
  assign line.scl_fall = ~sync_q[3] & scl_prev_q;
  assign line.start_det = scl_prev_q & sync_q[3] & sda_prev_q & ~sync_q[2];
  assign line.stop_det = scl_prev_q & sync_q[3] & ~sda_prev_q & sync_q[2];

endmodule

`default_nettype wire

// >>> hsr_chan.sv
/*
  one channel: holding register and output register, each power-down bits
  over conversion data.
  assumes write and update strobes are single-cycle pulses.
*/
`timescale 1ns/1ps
`default_nettype none

module hsr_chan
  import hsr_pkg::*;
#(
  parameter logic [SEL_W-1:0] CH_IDX = 2'h0
) (
  input wire logic core_clk,
  input wire logic rst_n,
  hsr_wr_if.chan wr,
  output logic [CH_W-1:0] hold_q,
  output logic [CH_W-1:0] out_q
);

  logic hit;
  logic out_en;
  logic [CH_W-1:0] hold_d;

  // a data write clears the power-down bits; a power-down write keeps data
  assign hit = (wr.sel == CH_IDX);
  assign hold_d = !(wr.hold_en && hit) ? hold_q :
                  wr.pd_only ? {wr.pd, hold_q[DATA_W-1:0]} : {PD_NORMAL, wr.data};
  assign out_en = wr.upd && (((wr.load == LOAD_SEL) && hit) || wr.load[LOAD_ALL_BIT]);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_q <= CH_RST;
      out_q <= CH_RST;
    end else begin
      hold_q <= hold_d;
      if (out_en) begin
        out_q <= hold_d;
      end
    end
  end

endmodule

`default_nettype wire

// >>> hsr_hs_write_rx.sv
/*
  high-speed write receiver of a quad 12-bit converter's two-wire slave:
  master code detection, address and control bytes, data pairs and
  power-down words, channel holding and output registers.
  assumes scl/sda come from pins (open drain, pulled up) and the bus clock is
  at most an eighth of core_clk; the sda driver is resolved outside.
*/
// What this block does
// - master code is never acknowledged
// - own write address gets acknowledged
// - address is 10011, pins, write bit
// - control byte acknowledged, fields decoded
// - control lsb picks power-down or data
// - data pairs repeat until stop/restart
// - power-down mode takes exactly two bytes
// - high byte is bits 11..4
// - low byte nibble is bits 3..0
// - power-down high byte top two bits
// - power-down low byte acknowledged, then end
// - update at falling edge ending ack
// - each channel holds 14-bit register
`timescale 1ns/1ps
`default_nettype none

module hsr_hs_write_rx
  import hsr_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic addr_pin_hi,
  input wire logic addr_pin_lo,
  output logic sda_o,
  output logic sda_oe_n,
  output logic hs_mode,
  output logic wr_done,
  output logic [hsr_pkg::NUM_CH*hsr_pkg::CH_W-1:0] chan_hold,
  output logic [hsr_pkg::NUM_CH*hsr_pkg::CH_W-1:0] chan_out
);

  hsr_line_if line ();
  hsr_wr_if wr ();

  hsr_phase_t phase_q, phase_d;
  logic [7:0] shift_q;
  logic [3:0] bit_cnt_q;
  logic ack_q;
  logic drive_q;
  logic hs_q;
  logic pend_data_q;
  logic pend_pd_q;
  logic upd_q;
  logic [SEL_W-1:0] sel_q;
  logic [1:0] load_q;
  logic [7:0] data_hi_q;
  logic [3:0] data_lo_q;
  logic [PD_W-1:0] pd_q;

  logic byte_done;
  logic ack_end;
  logic mcode_match;
  logic addr_match;
  logic want_ack;
  logic pend_any;

  // pin synchroniser and line event detector
  hsr_link_sync u_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .addr_pin_hi(addr_pin_hi),
    .addr_pin_lo(addr_pin_lo),
    .line(line)
  );

  // byte boundaries: eighth bit taken, then the ack slot ends on the next fall
  assign byte_done = line.scl_fall && !ack_q && (bit_cnt_q == BITS_PER_BYTE);
  assign ack_end = line.scl_fall && ack_q;
  assign pend_any = pend_data_q || pend_pd_q;

  // byte decoders
  assign mcode_match = (shift_q[7:MCODE_LSB] == MCODE_TOP);
  // fixed bits, pin bits, write bit
  assign addr_match = (shift_q[7:ADDR_FIX_LSB] == ADDR_FIXED) &&
                      (shift_q[ADDR_PIN_LSB+1:ADDR_PIN_LSB] == line.addr) &&
                      (shift_q[ADDR_RW_BIT] == ADDR_RW_WRITE);

  assign want_ack = (phase_q == PH_ADDR) ? addr_match :
                    (phase_q == PH_CTRL) || (phase_q == PH_HIGH) || (phase_q == PH_LOW) ||
                    (phase_q == PH_PDHI) || (phase_q == PH_PDLO);

  // next receive phase, evaluated at byte end and on line events
  always_comb begin
    phase_d = phase_q;
    if (line.stop_det) begin
      phase_d = PH_IDLE;
    end else if (line.start_det) begin
      phase_d = hs_q ? PH_ADDR : PH_MCODE;
    end else if (byte_done) begin
      unique case (phase_q)
        PH_IDLE: phase_d = PH_IDLE;
        PH_MCODE: phase_d = PH_IGNORE;
        PH_ADDR: phase_d = addr_match ? PH_CTRL : PH_IGNORE;
        PH_CTRL: phase_d = shift_q[CTRL_KIND_BIT] ? PH_PDHI : PH_HIGH;
        PH_HIGH: phase_d = PH_LOW;
        PH_LOW: phase_d = PH_HIGH;
        PH_PDHI: phase_d = PH_PDLO;
        PH_PDLO: phase_d = PH_IGNORE;
        PH_IGNORE: phase_d = PH_IGNORE;
      endcase
    end
  end

  // bit sampling on scl rise; ack slot spans one full scl low-high-low
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_q <= 8'h00;
      bit_cnt_q <= 4'h0;
      ack_q <= 1'b0;
      drive_q <= 1'b0;
    end else if (line.start_det || line.stop_det) begin
      bit_cnt_q <= 4'h0;
      ack_q <= 1'b0;
      drive_q <= 1'b0;
    end else if (byte_done) begin
      ack_q <= 1'b1;
      drive_q <= want_ack;
      bit_cnt_q <= 4'h0;
    end else if (ack_end) begin
      ack_q <= 1'b0;
      drive_q <= 1'b0;
    end else if (line.scl_rise && !ack_q && (bit_cnt_q != BITS_PER_BYTE)) begin
      shift_q <= {shift_q[6:0], line.sda};
      bit_cnt_q <= bit_cnt_q + 4'h1;
    end
  end

  // phase and speed mode
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_q <= PH_IDLE;
      hs_q <= 1'b0;
    end else begin
      phase_q <= phase_d;
      if (line.stop_det) begin
        hs_q <= 1'b0;
      end else if (byte_done && (phase_q == PH_MCODE) && mcode_match) begin
        // master code seen in slow mode
        hs_q <= 1'b1;
      end
    end
  end

  // control fields latched when the control byte completes
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_q <= 2'h0;
      load_q <= 2'h0;
    end else if (byte_done && (phase_q == PH_CTRL)) begin
      sel_q <= shift_q[CTRL_SEL_LSB+1:CTRL_SEL_LSB];
      load_q <= shift_q[CTRL_LOAD_LSB+1:CTRL_LOAD_LSB];
    end
  end

  // data bytes; the low nibble of the low byte is dropped
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      data_hi_q <= 8'h00;
      data_lo_q <= 4'h0;
      pd_q <= PD_NORMAL;
    end else if (byte_done) begin
      if (phase_q == PH_HIGH) begin
        data_hi_q <= shift_q;
      end
      if (phase_q == PH_LOW) begin
        data_lo_q <= shift_q[7:LOW_NIB_LSB];
      end
      if (phase_q == PH_PDHI) begin
        pd_q <= shift_q[7:PD_HI_LSB];
      end
    end
  end

  // a pending write waits for the ack to finish, so a restart inside the
  // ack slot drops it rather than updating with a half-seen acknowledge
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_data_q <= 1'b0;
      pend_pd_q <= 1'b0;
      upd_q <= 1'b0;
    end else begin
      upd_q <= ack_end && pend_any;
      if (line.start_det || line.stop_det || ack_end) begin
        pend_data_q <= 1'b0;
        pend_pd_q <= 1'b0;
      end else if (byte_done) begin
        pend_data_q <= (phase_q == PH_LOW);
        // low power-down byte closes the word
        pend_pd_q <= (phase_q == PH_PDLO);
      end
    end
  end

  // remember which kind of write the strobe carries
  logic pd_kind_q;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pd_kind_q <= 1'b0;
    end else if (ack_end && pend_any) begin
      pd_kind_q <= pend_pd_q;
    end
  end

  // channel strobe after the ack's falling edge
  assign wr.hold_en = upd_q;
  assign wr.upd = upd_q;
  assign wr.pd_only = pd_kind_q;
  assign wr.sel = sel_q;
  assign wr.load = load_q;
  assign wr.data = {data_hi_q, data_lo_q};
  assign wr.pd = pd_q;

  // one channel register pair per select code
  for (genvar i = 0; i < NUM_CH; i++) begin : g_chan
    hsr_chan #(
      .CH_IDX(SEL_W'(i))
    ) u_chan (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .wr(wr),
      .hold_q(chan_hold[i*CH_W +: CH_W]),
      .out_q(chan_out[i*CH_W +: CH_W])
    );
  end

  // open drain: data low is the only level we ever drive
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sda_o <= 1'b0;
      sda_oe_n <= 1'b1;
      hs_mode <= 1'b0;
      wr_done <= 1'b0;
    end else begin
      sda_o <= 1'b0;
      sda_oe_n <= !drive_q;
      hs_mode <= hs_q;
      wr_done <= upd_q;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  mcode_nack_a: assert property (byte_done && phase_q == PH_MCODE |-> ##2 sda_oe_n)
    else $error("master code was acknowledged");
  addr_ack_a: assert property (byte_done && phase_q == PH_ADDR && addr_match |-> ##2 !sda_oe_n)
    else $error("own address not acknowledged");
  foreign_addr_a: assert property (byte_done && phase_q == PH_ADDR && !addr_match
                                   |=> phase_q == PH_IGNORE ##1 sda_oe_n)
    else $error("foreign address accepted");
  ctrl_kind_a: assert property (byte_done && phase_q == PH_CTRL && !line.start_det && !line.stop_det
                                |=> phase_q == ($past(shift_q[CTRL_KIND_BIT]) ? PH_PDHI : PH_HIGH))
    else $error("control lsb misrouted");
  pair_loop_a: assert property (byte_done && phase_q == PH_LOW && !line.start_det && !line.stop_det
                                |=> phase_q == PH_HIGH)
    else $error("data pair did not loop");
  pd_two_a: assert property (byte_done && phase_q == PH_PDLO && !line.start_det && !line.stop_det
                             |=> phase_q == PH_IGNORE)
    else $error("more than two power-down bytes taken");
  hi_byte_a: assert property (byte_done && phase_q == PH_HIGH |=> data_hi_q == $past(shift_q))
    else $error("high byte not captured");
  update_edge_a: assert property (ack_end && pend_any |=> upd_q ##1 wr_done && !upd_q)
    else $error("update not issued after ack");
  stop_slow_a: assert property (line.stop_det |=> !hs_q && phase_q == PH_IDLE ##1 !hs_mode)
    else $error("stop did not leave high-speed mode");
  lo_nib_a: assert property (byte_done && phase_q == PH_LOW |=> data_lo_q == $past(shift_q[7:LOW_NIB_LSB]))
    else $error("low byte nibble not captured");
  pd_lo_ack_a: assert property (byte_done && phase_q == PH_PDLO |-> ##2 !sda_oe_n)
    else $error("power-down low byte not acknowledged");

endmodule

`default_nettype wire

// >>> hsr_bus_master.sv
/*
  behavioural two-wire bus master that drives the receiver's pins.
  assumes the bench resolves the open-drain data line with a pull-up and
  feeds the resolved level back on sda_line.
*/
`timescale 1ns/1ps
`default_nettype none

module hsr_bus_master (
  input wire logic core_clk,
  input wire logic sda_line,
  output logic scl,
  output logic sda_drv
);
  import hsr_pkg::*;

  int gap = 0; // extra low-phase cycles, for a slow master

  // both pins idle released
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end

  task automatic w(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // start or restart
  // long lead so the device has let go of an ack before sda rises
  task automatic start();
    w(4);
    sda_drv <= 1'b1;
    w(2);
    scl <= 1'b1;
    w(3);
    sda_drv <= 1'b0;
    w(3);
    scl <= 1'b0;
  endtask

  task automatic stop();
    w(4);
    sda_drv <= 1'b0;
    w(2);
    scl <= 1'b1;
    w(3);
    sda_drv <= 1'b1;
    // bus free time: the device needs a few cycles to see the stop
    w(6);
  endtask

  // one bus bit, 80 ns period, line sampled just before scl falls
  task automatic put_bit(input logic b, output logic seen);
    w(2 + gap);
    sda_drv <= b;
    w(2);
    scl <= 1'b1;
    w(4);
    seen = sda_line;
    scl <= 1'b0;
  endtask

  task automatic put_byte(input logic [7:0] v, output logic ack);
    logic s;
    w(4);
    for (int i = 7; i >= 0; i--) begin
      put_bit(v[i], s);
    end
    put_bit(1'b1, s);
    ack = ~s;
  endtask

  task automatic hs_open(input logic [2:0] free, output logic ack);
    start();
    put_byte({MCODE_TOP, free}, ack);
    start();
  endtask
endmodule

`default_nettype wire

// >>> testbench.sv
/*
  self-checking bench for the high-speed write receiver: bus sequences
  through the master model, expected values derived from the byte layout.
  assumes hsr_pkg, the design files and hsr_bus_master are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import hsr_pkg::*;

  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic a_hi = 1'b1;
  logic a_lo = 1'b0;
  logic scl;
  logic sda_drv;
  logic sda_o;
  logic sda_oe_n;
  logic hs_mode;
  logic wr_done;
  logic [NUM_CH*CH_W-1:0] chan_hold;
  logic [NUM_CH*CH_W-1:0] chan_out;
  wire sda_line;
  int bad_count = 0;
  int comparisons = 0;
  int done_cnt = 0;
  logic a;

  // pulled-up open-drain line shared by master and device
  assign sda_line = sda_drv & (sda_oe_n | sda_o);

  always #5 core_clk = ~core_clk;

  // count update pulses seen on the device side
  always @(posedge core_clk) begin
    if (wr_done === 1'b1) begin
      done_cnt <= done_cnt + 1;
    end
  end

  hsr_hs_write_rx DUT (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .scl_i(scl),
    .sda_i(sda_line),
    .addr_pin_hi(a_hi),
    .addr_pin_lo(a_lo),
    .sda_o(sda_o),
    .sda_oe_n(sda_oe_n),
    .hs_mode(hs_mode),
    .wr_done(wr_done),
    .chan_hold(chan_hold),
    .chan_out(chan_out)
  );

  hsr_bus_master m (
    .core_clk(core_clk),
    .sda_line(sda_line),
    .scl(scl),
    .sda_drv(sda_drv)
  );

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  function automatic logic [15:0] hd(input int ch);
    return 16'(chan_hold[ch*CH_W +: CH_W]);
  endfunction

  function automatic logic [15:0] ot(input int ch);
    return 16'(chan_out[ch*CH_W +: CH_W]);
  endfunction

  function automatic logic [7:0] adr(input logic [1:0] p, input logic rw);
    return {ADDR_FIXED, p, rw};
  endfunction

  function automatic logic [7:0] ctl(input logic [1:0] ld, input logic [1:0] sel, input logic kind);
    return {2'h0, ld, 1'h0, sel, kind};
  endfunction

  // one byte with the acknowledge we expect back
  task automatic tx(input logic [7:0] v, input logic exp_ack);
    logic k;
    m.put_byte(v, k);
    chk(16'(k), 16'(exp_ack));
  endtask

  // bounded wait: the update pulse trails the ack by a few cycles
  task automatic wait_done();
    int n;
    n = done_cnt;
    for (int i = 0; i < 30 && done_cnt == n; i++) begin
      @(posedge core_clk);
    end
  endtask

  task automatic pair(input logic [7:0] hi, input logic [7:0] lo);
    tx(hi, 1'b1);
    tx(lo, 1'b1);
    wait_done();
  endtask

  // watchdog: the tests need about 2.4k cycles, allow far more
  initial begin
    #400us;
    bad_count++;
    end_sim();
  end

  // main sequence
  initial begin
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    for (int c = 0; c < NUM_CH; c++) begin
      chk(hd(c), 16'h0000);
      chk(ot(c), 16'h0000);
    end
    chk(16'(sda_oe_n), 16'h0001);
    chk(16'(sda_o), 16'h0000);
    chk(16'(hs_mode), 16'h0000);
    $display("test reset done");
    m.hs_open(3'h5, a);
    chk(16'(a), 16'h0000);
    chk(16'(hs_mode), 16'h0001);
    tx(adr(2'h2, 1'b0), 1'b1);
    tx(ctl(2'h1, 2'h1, 1'b0), 1'b1);
    pair(8'hab, 8'hc0);
    chk(hd(1), 16'h0abc);
    chk(ot(1), 16'h0abc);
    pair(8'h12, 8'h3f);
    chk(ot(1), 16'h0123);
    chk(16'(done_cnt), 16'h0002);
    $display("test data pairs done");
    // hold-only write, then a power-down word on the same channel
    m.start();
    tx(adr(2'h2, 1'b0), 1'b1);
    tx(ctl(2'h0, 2'h2, 1'b0), 1'b1);
    pair(8'h5a, 8'h70);
    chk(hd(2), 16'h05a7);
    chk(ot(2), 16'h0000);
    m.start();
    tx(adr(2'h2, 1'b0), 1'b1);
    tx(ctl(2'h1, 2'h2, 1'b1), 1'b1);
    tx(8'h80, 1'b1);
    tx(8'h0f, 1'b1);
    wait_done();
    chk(hd(2), 16'h25a7);
    chk(ot(2), 16'h25a7);
    tx(8'hc0, 1'b0);
    chk(hd(2), 16'h25a7);
    $display("test power-down done");
    // slow master, update of every output at once
    m.gap = 3;
    m.start();
    tx(adr(2'h2, 1'b0), 1'b1);
    tx(ctl(2'h2, 2'h0, 1'b0), 1'b1);
    pair(8'h01, 8'h20);
    m.gap = 0;
    chk(ot(0), 16'h0012);
    chk(ot(1), 16'h0123);
    chk(ot(2), 16'h25a7);
    chk(ot(3), 16'h0000);
    m.stop();
    chk(16'(hs_mode), 16'h0000);
    $display("test load all done");
    // refusals: slow-mode address, foreign pins, read direction
    m.start();
    tx(adr(2'h2, 1'b0), 1'b0);
    m.stop();
    m.hs_open(3'h0, a);
    tx(adr(2'h1, 1'b0), 1'b0);
    tx(ctl(2'h1, 2'h1, 1'b0), 1'b0);
    m.start();
    tx(adr(2'h2, 1'b1), 1'b0);
    @(posedge core_clk);
    a_hi <= 1'b0;
    a_lo <= 1'b1;
    m.start();
    tx(adr(2'h1, 1'b0), 1'b1);
    m.stop();
    chk(hd(1), 16'h0123);
    chk(16'(done_cnt), 16'h0005);
    $display("test refusals done");
    // second reset in mid-run clears everything
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    for (int c = 0; c < NUM_CH; c++) begin
      chk(hd(c), 16'h0000);
      chk(ot(c), 16'h0000);
    end
    rst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    chk(16'(sda_oe_n), 16'h0001);
    chk(16'(hs_mode), 16'h0000);
    chk(16'(wr_done), 16'h0000);
    $display("test second reset done");
    end_sim();
  end
endmodule

`default_nettype wire
